// file: design/usw_pkg.sv
// package of constants and types for the serial wire-mode control block
package usw_pkg;
  // register word indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL       = 8'h0d;
  localparam logic [7:0] IDX_STATUS     = 8'h0e;
  localparam logic [7:0] IDX_SHIFT      = 8'h0f;
  localparam logic [7:0] IDX_PORT_OUT   = 8'h10;
  localparam logic [7:0] IDX_PORT_DIR   = 8'h11;
  localparam logic [7:0] IDX_IRQ_GLOBAL = 8'h12;

  // control register field positions
  localparam int CTRL_START_IE = 7;
  localparam int CTRL_WRAP_IE  = 6;
  localparam int CTRL_WM_HI    = 5;
  localparam int CTRL_WM_LO    = 4;
  localparam int CTRL_CS_HI    = 3;
  localparam int CTRL_CS_LO    = 2;
  localparam int CTRL_SOFT_CLK = 1;
  localparam int CTRL_TOGGLE   = 0;

  // status register field positions
  localparam int STAT_START = 7;
  localparam int STAT_WRAP  = 6;
  localparam int STAT_STOP  = 5;
  localparam int STAT_COLL  = 4;
  localparam int STAT_CNT_HI = 3;

  // port bit that each serial pin uses
  localparam int PIN_SCL = 4;
  localparam int PIN_DO  = 5;
  localparam int PIN_SDA = 6;

  // reset values, and the count that wraps to zero
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] PORT_RST  = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [3:0] CNT_MAX   = 4'hf;

  // link clock may run at most at core clock divided by this
  localparam int LINK_MAX_DIV = 2;
  localparam int CORE_HZ      = 100_000_000;
  localparam int LINK_MAX_HZ  = CORE_HZ / LINK_MAX_DIV;

  typedef enum logic [1:0] {
    WM_OFF,
    WM_THREE,
    WM_TWO,
    WM_TWO_HOLD
  } usw_wire_e;
endpackage

// file: design/usw_ctrl.sv
// serial unit control register, wire-mode pin logic, counter and flags
//
// Function
// - shift clock runs at most half the core clock; sets data rate.
// - as two-wire slave, hold scl low until ready for more data.
// - counter on external clock counts both pin edges.
// - counter preset to f overflows on next external edge, flag and irq.
// - software strobe can drive counter into overflow as software irq.
// - control register layout, reset zero, two strobe bits write-only.
// - start irq enable plus global enable takes pending start flag.
// - wrap irq enable plus global enable takes pending wrap flag.
// - wire mode changes outputs and start/stop detection; inputs work in every mode.
// - mode zero disables outputs, hold, start detector; port controls pins.
// - three-wire drives data out over port bit; port bit sets pull-up.
// - three-wire leaves input and clock pins as port; toggle makes clock.
// - two-wire makes sda and scl open-collector, enabled by direction bits.
// - enabled sda pulled low when shift msb or port bit is zero.
// - enabled scl pulled low when port bit zero or start hold.
// - detected start holds scl low until start flag cleared.
// - two-wire disables sda and scl pull-ups; inputs unaffected.
// - mode three also holds scl low from overflow until flag cleared.
// - wrap flag sets on 15 to 0; write one clears, releasing hold.
// - clock source field and strobe select shift and counter clocks.
// - start flag on start condition in two-wire, else any clock edge.
`timescale 1ns/1ps
module usw_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        timer_match,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             scl_pullup,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             sda_pullup,
  output logic             dout_out,
  output logic             dout_oe,
  output logic             dout_pullup,
  output logic             start_irq,
  output logic             wrap_irq
);

  typedef struct packed {
    logic [7:2] ctrl;
    logic       clk_sel;
    logic       gie;
    logic [7:0] port_out;
    logic [7:0] port_dir;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic       start_flag;
    logic       wrap_flag;
    logic       stop_flag;
    logic       start_hold;
    logic       out_latch;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_filt;
    logic       sda_filt;
    logic       ap_valid;
    logic       ap_write;
    logic [7:0] ap_index;
    logic [31:0] rdata;
  } usw_state_s;

  usw_state_s st_ff;
  usw_state_s nxt_st;

  function automatic logic hit(input logic [7:0] idx,
                               input logic [7:0] want);
    hit = (idx == want);
  endfunction

  usw_pkg::usw_wire_e wm;
  logic       two_wire;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_shift;
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_edge;
  logic       sda_rise;
  logic       sda_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       shift_tick;
  logic [1:0] cs_eff;
  logic       sel_eff;
  logic       cnt_tick;
  logic       wrap_now;
  logic       wrap_hold;
  logic       take_addr;
  logic [7:0] rd_ctrl;
  logic [7:0] rd_status;
  logic [7:0] rd_mux;

  assign wm        = usw_pkg::usw_wire_e'(st_ff.ctrl[usw_pkg::CTRL_WM_HI:
                                                     usw_pkg::CTRL_WM_LO]);
  assign two_wire  = st_ff.ctrl[usw_pkg::CTRL_WM_HI];
  // single-cycle writes, no wait states: the bus never stalls
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdata;
  assign take_addr = hsel && hready && htrans[1];
  assign wr_ctrl   = st_ff.ap_valid && st_ff.ap_write &&
                     hit(st_ff.ap_index, usw_pkg::IDX_CTRL);
  assign wr_status = st_ff.ap_valid && st_ff.ap_write &&
                     hit(st_ff.ap_index, usw_pkg::IDX_STATUS);
  assign wr_shift  = st_ff.ap_valid && st_ff.ap_write &&
                     hit(st_ff.ap_index, usw_pkg::IDX_SHIFT);

  // filtered pin edges; a filtered level cannot change two cycles running
  always_comb begin
    scl_rise = (st_ff.scl_sync[2] == st_ff.scl_sync[1]) &&
               st_ff.scl_sync[2] && !st_ff.scl_filt;
    scl_fall = (st_ff.scl_sync[2] == st_ff.scl_sync[1]) &&
               !st_ff.scl_sync[2] && st_ff.scl_filt;
    sda_rise = (st_ff.sda_sync[2] == st_ff.sda_sync[1]) &&
               st_ff.sda_sync[2] && !st_ff.sda_filt;
    sda_fall = (st_ff.sda_sync[2] == st_ff.sda_sync[1]) &&
               !st_ff.sda_sync[2] && st_ff.sda_filt;
  end
  assign scl_edge   = scl_rise || scl_fall;
  assign start_cond = two_wire && sda_fall && st_ff.scl_filt;
  assign stop_cond  = two_wire && sda_rise && st_ff.scl_filt;

  // a control write counts at once, so one write can both select and strobe
  assign cs_eff  = wr_ctrl ?
                   hwdata[usw_pkg::CTRL_CS_HI:usw_pkg::CTRL_CS_LO] :
                   st_ff.ctrl[usw_pkg::CTRL_CS_HI:usw_pkg::CTRL_CS_LO];
  assign sel_eff = wr_ctrl ? hwdata[usw_pkg::CTRL_SOFT_CLK] : st_ff.clk_sel;

  // clock source selection for shift register and counter
  always_comb begin
    shift_tick = 1'b0;
    cnt_tick   = 1'b0;
    unique case (cs_eff)
      2'b00: begin
        shift_tick = wr_ctrl && hwdata[usw_pkg::CTRL_SOFT_CLK];
        cnt_tick   = shift_tick;
      end
      2'b01: begin
        shift_tick = timer_match;
        cnt_tick   = timer_match;
      end
      2'b10, 2'b11: begin
        // inputs sampled in every wire mode, outputs off or not
        shift_tick = cs_eff[0] ? scl_fall : scl_rise;
        cnt_tick   = sel_eff ?
                     (wr_ctrl && hwdata[usw_pkg::CTRL_TOGGLE])
                   : scl_edge;
      end
    endcase
  end

  assign wrap_now  = cnt_tick && (st_ff.cnt == usw_pkg::CNT_MAX);
  assign wrap_hold = (wm == usw_pkg::WM_TWO_HOLD) && st_ff.wrap_flag;

  always_comb begin
    rd_ctrl = {st_ff.ctrl, 2'b00};
    rd_status = {st_ff.start_flag, st_ff.wrap_flag, st_ff.stop_flag,
                 two_wire && (st_ff.shreg[7] != st_ff.sda_filt),
                 st_ff.cnt};
    rd_mux = 8'h00;
    if (hit(haddr[9:2], usw_pkg::IDX_CTRL)) begin
      rd_mux = rd_ctrl;
    end else if (hit(haddr[9:2], usw_pkg::IDX_STATUS)) begin
      rd_mux = rd_status;
    end else if (hit(haddr[9:2], usw_pkg::IDX_SHIFT)) begin
      rd_mux = st_ff.shreg;
    end else if (hit(haddr[9:2], usw_pkg::IDX_PORT_OUT)) begin
      rd_mux = st_ff.port_out;
    end else if (hit(haddr[9:2], usw_pkg::IDX_PORT_DIR)) begin
      rd_mux = st_ff.port_dir;
    end else if (hit(haddr[9:2], usw_pkg::IDX_IRQ_GLOBAL)) begin
      rd_mux = {7'h00, st_ff.gie};
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // bus address phase; read data is captured here for the data phase
    nxt_st.ap_valid = take_addr;
    nxt_st.ap_write = hwrite;
    nxt_st.ap_index = haddr[9:2];
    if (take_addr && !hwrite) begin
      nxt_st.rdata = {24'h000000, rd_mux};
    end
    // first stage feeds only the second
    nxt_st.scl_sync = {st_ff.scl_sync[1:0], scl_in};
    nxt_st.sda_sync = {st_ff.sda_sync[1:0], sda_in};
    if (st_ff.scl_sync[2] == st_ff.scl_sync[1]) begin
      nxt_st.scl_filt = st_ff.scl_sync[2];
    end
    if (st_ff.sda_sync[2] == st_ff.sda_sync[1]) begin
      nxt_st.sda_filt = st_ff.sda_sync[2];
    end
    if (wr_ctrl) begin
      nxt_st.ctrl    = hwdata[7:2];
      nxt_st.clk_sel = hwdata[usw_pkg::CTRL_SOFT_CLK];
      if (hwdata[usw_pkg::CTRL_TOGGLE]) begin
        nxt_st.port_out[usw_pkg::PIN_SCL] =
          !st_ff.port_out[usw_pkg::PIN_SCL];
      end
    end
    if (st_ff.ap_valid && st_ff.ap_write &&
        hit(st_ff.ap_index, usw_pkg::IDX_PORT_DIR)) begin
      nxt_st.port_dir = hwdata[7:0];
    end
    if (st_ff.ap_valid && st_ff.ap_write &&
        hit(st_ff.ap_index, usw_pkg::IDX_IRQ_GLOBAL)) begin
      nxt_st.gie = hwdata[0];
    end
    if (st_ff.ap_valid && st_ff.ap_write &&
        hit(st_ff.ap_index, usw_pkg::IDX_PORT_OUT)) begin
      nxt_st.port_out = hwdata[7:0];
    end
    // a write to the data register beats a shift in the same cycle
    if (wr_shift) begin
      nxt_st.shreg = hwdata[7:0];
    end else if (shift_tick) begin
      nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_filt};
    end
    if (wr_status) begin
      nxt_st.cnt = hwdata[usw_pkg::STAT_CNT_HI:0];
    end else if (cnt_tick) begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
    // output latch: transparent on internal clocks, else moves on the
    // edge opposite to sampling so data stays stable across the sample
    if (!st_ff.ctrl[usw_pkg::CTRL_CS_HI]) begin
      nxt_st.out_latch = nxt_st.shreg[7];
    end else if (st_ff.ctrl[usw_pkg::CTRL_CS_LO] ? scl_rise : scl_fall) begin
      nxt_st.out_latch = nxt_st.shreg[7];
    end else if (wr_shift) begin
      nxt_st.out_latch = hwdata[7];
    end
    // flags: for start and stop a set in the same cycle as a clear wins; any status write blocks a wrap set
    if (wr_status && hwdata[usw_pkg::STAT_START]) begin
      nxt_st.start_flag = 1'b0;
    end
    if (two_wire ? start_cond : scl_edge) begin
      nxt_st.start_flag = 1'b1;
    end
    if (wr_status && hwdata[usw_pkg::STAT_WRAP]) begin
      nxt_st.wrap_flag = 1'b0;
    end
    if (wrap_now && !wr_status) begin
      nxt_st.wrap_flag = 1'b1;
    end
    if (wr_status && hwdata[usw_pkg::STAT_STOP]) begin
      nxt_st.stop_flag = 1'b0;
    end
    if (stop_cond) begin
      nxt_st.stop_flag = 1'b1;
    end
    // start hold engages on the master's falling scl after the start
    if (!two_wire || !nxt_st.start_flag) begin
      nxt_st.start_hold = 1'b0;
    end else if (st_ff.start_flag && scl_fall) begin
      nxt_st.start_hold = 1'b1;
    end
  end

  // pin drivers; sda and scl only ever pull low in two-wire modes
  always_comb begin
    scl_out     = st_ff.port_out[usw_pkg::PIN_SCL];
    scl_oe      = st_ff.port_dir[usw_pkg::PIN_SCL];
    scl_pullup  = !st_ff.port_dir[usw_pkg::PIN_SCL] &&
                  st_ff.port_out[usw_pkg::PIN_SCL];
    sda_out     = st_ff.port_out[usw_pkg::PIN_SDA];
    sda_oe      = st_ff.port_dir[usw_pkg::PIN_SDA];
    sda_pullup  = !st_ff.port_dir[usw_pkg::PIN_SDA] &&
                  st_ff.port_out[usw_pkg::PIN_SDA];
    dout_out    = st_ff.port_out[usw_pkg::PIN_DO];
    dout_oe     = st_ff.port_dir[usw_pkg::PIN_DO];
    dout_pullup = !st_ff.port_dir[usw_pkg::PIN_DO] &&
                  st_ff.port_out[usw_pkg::PIN_DO];
    unique case (wm)
      usw_pkg::WM_OFF: begin
        scl_out = st_ff.port_out[usw_pkg::PIN_SCL];
      end
      usw_pkg::WM_THREE: begin
        dout_out = st_ff.out_latch;
      end
      usw_pkg::WM_TWO, usw_pkg::WM_TWO_HOLD: begin
        sda_out    = 1'b0;
        sda_oe     = st_ff.port_dir[usw_pkg::PIN_SDA] &&
                     (!st_ff.out_latch ||
                      !st_ff.port_out[usw_pkg::PIN_SDA]);
        scl_out    = 1'b0;
        // stretching: the slave keeps scl low while a hold is pending
        scl_oe     = st_ff.port_dir[usw_pkg::PIN_SCL] &&
                     (!st_ff.port_out[usw_pkg::PIN_SCL] ||
                      st_ff.start_hold || wrap_hold);
        sda_pullup = 1'b0;
        scl_pullup = 1'b0;
      end
    endcase
  end

  assign start_irq = st_ff.start_flag && st_ff.ctrl[usw_pkg::CTRL_START_IE] &&
                     st_ff.gie;
  assign wrap_irq  = st_ff.wrap_flag && st_ff.ctrl[usw_pkg::CTRL_WRAP_IE] &&
                     st_ff.gie;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{ctrl: usw_pkg::CTRL_RST[7:2], port_out: usw_pkg::PORT_RST,
                 port_dir: usw_pkg::PORT_RST, shreg: usw_pkg::SHIFT_RST,
                 cnt: usw_pkg::CNT_RST, rdata: 32'h00000000,
                 // lines idle high; a zero here would fake an edge at reset
                 scl_sync: 3'h7, sda_sync: 3'h7,
                 scl_filt: 1'h1, sda_filt: 1'h1,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_start_seen;
    start_cond;
  endsequence

  chk_edge_spacing: assert property (scl_edge |=> !scl_edge)
    else $error("filtered scl edges in consecutive cycles");
  chk_wrap_sets: assert property (wrap_now && !wr_status |=>
      st_ff.wrap_flag && st_ff.cnt == 4'h0)
    else $error("counter wrap did not set flag");
  chk_soft_strobe: assert property (wr_ctrl &&
      hwdata[usw_pkg::CTRL_SOFT_CLK] &&
      hwdata[usw_pkg::CTRL_CS_HI:usw_pkg::CTRL_CS_LO] == 2'b00 |=>
      st_ff.cnt == $past(st_ff.cnt) + 4'h1)
    else $error("software strobe did not advance counter");
  chk_both_edges: assert property (cs_eff[1] && !sel_eff && scl_edge &&
      !wr_status |=>
      st_ff.cnt == $past(st_ff.cnt) + 4'h1)
    else $error("external edge did not advance counter");
  chk_start_flag: assert property (seq_start_seen |=>
      st_ff.start_flag)
    else $error("start condition not flagged");
  chk_wrap_irq: assert property ($rose(st_ff.wrap_flag) &&
      st_ff.ctrl[usw_pkg::CTRL_WRAP_IE] && st_ff.gie |-> wrap_irq)
    else $error("wrap interrupt not raised");
  chk_sda_pull: assert property (two_wire &&
      st_ff.port_dir[usw_pkg::PIN_SDA] && !st_ff.out_latch |->
      sda_oe && !sda_out)
    else $error("sda not pulled low");
  chk_start_hold: assert property (two_wire && st_ff.start_hold &&
      st_ff.port_dir[usw_pkg::PIN_SCL] |-> scl_oe)
    else $error("scl not held after start");
  chk_wrap_hold: assert property ((wm == usw_pkg::WM_TWO_HOLD) &&
      st_ff.wrap_flag && st_ff.port_dir[usw_pkg::PIN_SCL] |->
      scl_oe && !scl_out)
    else $error("scl not held after wrap");
  chk_flag_sticky: assert property (st_ff.wrap_flag &&
      !(wr_status && hwdata[usw_pkg::STAT_WRAP]) |=>
      st_ff.wrap_flag)
    else $error("wrap flag cleared without write");
  chk_pullup_off: assert property (two_wire |->
      !sda_pullup && !scl_pullup)
    else $error("pull-up on in two-wire mode");

endmodule // usw_ctrl

// file: bench/usw_bus_peer.sv
// serial bus partner: open-drain master on the scl and sda wires
`timescale 1ns/1ps
module usw_bus_peer (
  input  wire logic scl_oe,
  input  wire logic scl_out,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl_wire,
  output logic      sda_wire
);
  logic scl_low;
  logic sda_low;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // external resistor pulls a released line high; low always wins
  assign scl_wire = scl_low ? 1'b0 : (scl_oe ? scl_out : 1'b1);
  assign sda_wire = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

  // one clock pulse; a half period of 40 ns keeps scl far below half the core rate
  task automatic pulse(input int half);
    scl_low = 1'b1;
    #(half);
    scl_low = 1'b0;
    // a slave may stretch the low phase, so wait until the line rises
    for (int i = 0; i < 100 && scl_wire !== 1'b1; i++) #(half);
    #(half);
  endtask

  // sda falls while scl is high, then scl is pulled low
  task automatic start_cond();
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #80;
  endtask

  // software clears the start flag to free scl, the master only lets go
  task automatic release_all();
    sda_low = 1'b0;
    scl_low = 1'b0;
  endtask
endmodule // usw_bus_peer

// file: bench/usw_ctrl_tb.sv
// self-checking bench for the serial wire-mode control block
`timescale 1ns/1ps
module usw_ctrl_tb;
  localparam logic [7:0] CT = usw_pkg::IDX_CTRL;
  localparam logic [7:0] ST = usw_pkg::IDX_STATUS;
  localparam logic [7:0] SH = usw_pkg::IDX_SHIFT;
  localparam logic [7:0] PO = usw_pkg::IDX_PORT_OUT;
  localparam logic [7:0] PD = usw_pkg::IDX_PORT_DIR;
  localparam logic [7:0] GI = usw_pkg::IDX_IRQ_GLOBAL;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        timer_match, scl_in, scl_out, scl_oe, scl_pullup;
  logic        sda_in, sda_out, sda_oe, sda_pullup;
  logic        dout_out, dout_oe, dout_pullup, start_irq, wrap_irq;
  int          n_mismatch;
  int          checks_done;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  usw_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_match(timer_match),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .scl_pullup(scl_pullup), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .sda_pullup(sda_pullup), .dout_out(dout_out),
    .dout_oe(dout_oe), .dout_pullup(dout_pullup),
    .start_irq(start_irq), .wrap_irq(wrap_irq));

  usw_bus_peer peer (.scl_oe(scl_oe), .scl_out(scl_out),
    .sda_oe(sda_oe), .sda_out(sda_out),
    .scl_wire(scl_in), .sda_wire(sda_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; #1 at the end lets register updates land
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[7:0];
    #1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input logic [7:0] msk);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r & msk, exp);
  endtask

  // pin changes pass a three-stage filter before they count
  task automatic settle();
    repeat (6) @(posedge hclk);
    #1;
  endtask

  task automatic t_reset();
    rd_chk(CT, 8'h00, 8'hff);
    rd_chk(ST, 8'h00, 8'hff);
    chk({7'h0, scl_oe | sda_oe | dout_oe}, 8'h00);
    chk({6'h0, hresp, ~hreadyout}, 8'h00);
    wr(CT, 8'hfc);
    rd_chk(CT, 8'hfc, 8'hff);
    wr(CT, 8'h00);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00, 8'hff);
  endtask

  // outputs off, counter on both external edges, preset one below wrap
  task automatic t_extcount();
    wr(ST, 8'hee);
    wr(CT, 8'h08);
    peer.scl_low = 1'b1;
    settle();
    rd_chk(ST, 8'h0f, 8'h4f);
    peer.scl_low = 1'b0;
    settle();
    rd_chk(ST, 8'hc0, 8'hcf);
    rd_chk(SH, 8'h01, 8'hff);
  endtask

  task automatic t_irq();
    wr(GI, 8'h01);
    wr(CT, 8'h80);
    chk({6'h0, start_irq, wrap_irq}, 8'h02);
    wr(CT, 8'h40);
    chk({6'h0, start_irq, wrap_irq}, 8'h01);
    wr(GI, 8'h00);
    chk({6'h0, start_irq, wrap_irq}, 8'h00);
    wr(ST, 8'hcf);
    wr(GI, 8'h01);
    chk({6'h0, start_irq, wrap_irq}, 8'h00);
    wr(CT, 8'h42);
    settle();
    chk({6'h0, start_irq, wrap_irq}, 8'h01);
    rd_chk(CT, 8'h40, 8'hff);
    wr(ST, 8'hce);
    wr(CT, 8'h04);
    @(posedge hclk) timer_match <= 1'b1;
    @(posedge hclk) timer_match <= 1'b0;
    settle();
    rd_chk(ST, 8'h0f, 8'h4f);
  endtask

  task automatic t_two();
    wr(ST, 8'hee);
    wr(SH, 8'h80);
    wr(PO, 8'h50);
    wr(PD, 8'h50);
    wr(CT, 8'h20);
    chk({4'h0, scl_oe & ~scl_out, sda_oe & ~sda_out,
         scl_pullup, sda_pullup}, 8'h00);
    peer.start_cond();
    settle();
    peer.release_all();
    settle();
    chk({7'h0, scl_oe & ~scl_out}, 8'h01);
    chk({7'h0, scl_in}, 8'h00);
    rd_chk(ST, 8'h80, 8'h80);
    wr(ST, 8'h80);
    settle();
    chk({7'h0, scl_oe & ~scl_out}, 8'h00);
    wr(PO, 8'h10);
    chk({7'h0, sda_oe & ~sda_out}, 8'h01);
    wr(PO, 8'h40);
    chk({7'h0, scl_oe & ~scl_out}, 8'h01);
    wr(PD, 8'h40);
    chk({7'h0, scl_oe}, 8'h00);
  endtask

  task automatic t_hold();
    // drop the start hold first; preset f so the pulse's fall wraps
    wr(ST, 8'hef);
    wr(PO, 8'h50);
    wr(PD, 8'h50);
    wr(CT, 8'h38);
    peer.pulse(40);
    settle();
    chk({7'h0, scl_oe & ~scl_out}, 8'h01);
    rd_chk(ST, 8'h40, 8'h4f);
    wr(ST, 8'h40);
    settle();
    chk({7'h0, scl_oe & ~scl_out}, 8'h00);
  endtask

  task automatic t_three();
    wr(PD, 8'h20);
    wr(SH, 8'h80);
    wr(CT, 8'h10);
    chk({5'h0, dout_oe, dout_out, dout_pullup}, 8'h06);
    wr(SH, 8'h00);
    chk({5'h0, dout_oe, dout_out, dout_pullup}, 8'h04);
    wr(PD, 8'h00);
    wr(PO, 8'h20);
    chk({6'h0, dout_oe, dout_pullup}, 8'h01);
    wr(CT, 8'h11);
    rd_chk(PO, 8'h30, 8'hff);
    wr(ST, 8'h0e);
    wr(CT, 8'h1a);
    wr(CT, 8'h1b);
    wr(CT, 8'h1b);
    rd_chk(ST, 8'h40, 8'h4f);
    wr(CT, 8'h00);
    wr(PD, 8'h20);
    wr(PO, 8'h00);
    wr(SH, 8'h80);
    chk({5'h0, dout_oe, dout_out, dout_pullup}, 8'h04);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    timer_match = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_extcount();
    t_irq();
    t_two();
    t_hold();
    t_three();
    close_out();
  end

  // the whole run needs some 650 cycles; this cuts a hang short
  initial begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule // usw_ctrl_tb
